// *** rtl/ppi_pkg.sv ***
// Shared constants, register map and types of the protected port isolation filter.
package ppi_pkg;
  // Port set and identifier widths.
  localparam int NUM_PORTS = 8;
  localparam int PIDX_W = 3;
  localparam int VLAN_W = 13;
  localparam int GRP_W = 4;
  localparam int MAP_DEPTH = 1024;
  localparam int MAP_AW = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int DESC_W = PIDX_W + VLAN_W + 2 + NUM_PORTS + 2;
  // Reserved internal VLAN range.
  localparam logic [VLAN_W-1:0] INT_VLAN_LO = 13'h1C00;
  localparam logic [VLAN_W-1:0] INT_VLAN_HI = 13'h1FFF;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PROT = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_VLAN = 8'h0C;
  localparam logic [7:0] ADDR_ATTR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_VCREATE = 8'h18;
  localparam logic [7:0] ADDR_STP = 8'h1C;
  localparam logic [7:0] ADDR_MAPIDX = 8'h20;
  localparam logic [7:0] ADDR_MAPDATA = 8'h24;
  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FV_BIT = 1;
  localparam int CMD_PORT_LSB = 0;
  localparam int CMD_EN_BIT = 8;
  localparam int VLAN_LSB = 16;
  localparam int VLAN_VALID_BIT = 31;
  localparam int AGG_LSB = 4;
  localparam int NODE_LSB = 8;
  localparam int ST_REJ_BIT = 0;
  localparam int ST_CODE_LSB = 4;
  localparam int ST_CNT_LSB = 16;
  // Outcome of the last configuration request.
  typedef enum logic [3:0] {
    REJ_NONE = 4'h0, REJ_NO_GLOBAL = 4'h1, REJ_NO_VLAN = 4'h2, REJ_NO_UPLINK = 4'h3,
    REJ_AGG_NODE = 4'h4, REJ_MAP_FULL = 4'h5, REJ_NO_FV = 4'h6, REJ_RESERVED = 4'h7
  } ppi_rej_e;
  // Ingress tag classes.
  typedef enum logic [1:0] {
    TAG_NONE = 2'h0, TAG_PRIO = 2'h1, TAG_VLAN = 2'h2, TAG_OTHER = 2'h3
  } ppi_tag_e;
endpackage

// *** rtl/ppi_fifo.sv ***
// Descriptor FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ppi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW:0] next_wptr;
  logic [AW:0] next_rptr;
  logic push;
  logic pop;

  // Full and empty are kept as flops so both handshakes leave a register.
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;
  assign next_wptr = push ? wptr + 1'b1 : wptr;
  assign next_rptr = pop ? rptr + 1'b1 : rptr;
  assign rd_data = mem[rptr[AW-1:0]];

  // Pointer and flag update.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= '0;
      rptr <= '0;
      wr_ready <= 1'b1;
      rd_valid <= 1'b0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      wr_ready <= !((next_wptr[AW] != next_rptr[AW]) && (next_wptr[AW-1:0] == next_rptr[AW-1:0]));
      rd_valid <= (next_wptr != next_rptr);
    end
  end

  // Storage has no reset; only written entries are ever read.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= wr_data;
    end
  end
endmodule // ppi_fifo

// *** rtl/ppi_map_mem.sv ***
// Internal VLAN mapping table with registered read data.
`timescale 1ns/1ps
module ppi_map_mem #(
  parameter int AW = 10,
  parameter int DW = 13
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // One write port and one registered read port.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // ppi_map_mem

// *** rtl/ppi_filter.sv ***
// Protected port isolation filter with APB configuration and descriptor stream.
`timescale 1ns/1ps
// Notes on behaviour
// - Frames from a protected port leave only through unprotected ports.
// - Software-injected frames get the same protected egress filtering.
// - Protected ports stay isolated even inside one VLAN.
// - Only untagged, priority-tagged or VLAN-tagged frames are accepted.
// - An uplink frame may reach every protected port of its VLAN.
// - Per-port protection is refused unless the global enable is set.
// - A protected port moves to an internal VLAN in 7168 to 8191.
// - At most 1024 internal VLAN mappings exist.
// - Each internal VLAN behaves as an isolated secondary VLAN.
// - With global enable set, creating VLANs 7168 to 8191 is refused.
// - Protection is refused on a port without a configured VLAN.
// - After reset every port is unprotected, acting as uplink.
// - Protection needs an existing unprotected uplink in the same VLAN.
// - Multi-chassis aggregation needs an uplink on every member node.
// - The global enable may be set only with fabric_virtualization on.
// - Spanning tree stays blocked on VLANs holding a protected port.
// - Internal VLANs are chosen locally in configuration order.
// - Each port or group has its own designation; many uplinks allowed.
module ppi_filter
  import ppi_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [PIDX_W-1:0] in_port,
  input wire logic [VLAN_W-1:0] in_vlan,
  input wire logic [1:0] in_tag,
  input wire logic [NUM_PORTS-1:0] in_dest,
  input wire logic in_flood,
  input wire logic in_sw,
  output logic out_valid,
  input wire logic out_ready,
  output logic [NUM_PORTS-1:0] out_mask,
  output logic [VLAN_W-1:0] out_vlan,
  output logic out_drop,
  output logic [NUM_PORTS-1:0] stp_block
);
  // Configuration state.
  logic glob_en;
  logic fab_virt;
  logic [NUM_PORTS-1:0] prot;
  logic [NUM_PORTS-1:0] vlan_valid;
  logic [VLAN_W-1:0] port_vlan [NUM_PORTS];
  logic [GRP_W-1:0] agg_grp [NUM_PORTS];
  logic [GRP_W-1:0] node_id [NUM_PORTS];
  logic [MAP_AW-1:0] map_idx [NUM_PORTS];
  logic [MAP_AW:0] alloc_cnt;
  logic last_rej;
  ppi_rej_e last_code;
  logic [MAP_AW-1:0] map_rd_idx;
  logic [VLAN_W-1:0] map_rdata;
  // Bus and command decode.
  logic apb_setup;
  logic apb_wr;
  logic [PIDX_W-1:0] cmd_p;
  logic cmd_wr;
  logic cmd_en;
  logic cmd_new;
  ppi_rej_e cmd_rej;
  logic uplink_ok;
  logic agg_ok;
  logic [NUM_PORTS-1:0] same_vlan_cmd;
  logic [NUM_PORTS-1:0] uplink_cmd;
  logic [NUM_PORTS-1:0] next_stp;
  // Stream path.
  logic f_valid;
  logic f_ready;
  logic [DESC_W-1:0] f_data;
  logic pop;
  logic [PIDX_W-1:0] f_src;
  logic [VLAN_W-1:0] f_vlan;
  logic [1:0] f_tag;
  logic [NUM_PORTS-1:0] f_dest;
  logic f_flood;
  logic [NUM_PORTS-1:0] member_src;
  logic [NUM_PORTS-1:0] src_bit;
  logic [NUM_PORTS-1:0] next_mask;

  // The bus answers after one wait state; writes land on the pready edge.
  assign apb_setup = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  assign cmd_p = pwdata[CMD_PORT_LSB +: PIDX_W];
  assign cmd_wr = apb_wr && (paddr == ADDR_CMD);
  assign cmd_en = pwdata[CMD_EN_BIT];
  assign uplink_ok = |uplink_cmd;
  // A port that is already protected keeps its mapping and needs no new entry.
  assign cmd_new = cmd_wr && cmd_en && (cmd_rej == REJ_NONE) && !prot[cmd_p];

  // Per-port comparisons against the command port and the frame source.
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      assign same_vlan_cmd[g] = vlan_valid[g] && (port_vlan[g] == port_vlan[cmd_p]);
      assign uplink_cmd[g] = same_vlan_cmd[g] && !prot[g] && (cmd_p != g);
      assign member_src[g] = vlan_valid[g] && (port_vlan[g] == port_vlan[f_src]);
      assign src_bit[g] = (f_src == g);
    end
  endgenerate

  // A port is blocked when any protected port shares its VLAN.
  // Kept in a process so that every VLAN change re-evaluates it.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_stp[p] = 1'b0;
      for (int q = 0; q < NUM_PORTS; q++) begin
        if (vlan_valid[p] && vlan_valid[q] && prot[q] && (port_vlan[q] == port_vlan[p])) begin
          next_stp[p] = 1'b1;
        end
      end
    end
  end

  // Every node of a multi-chassis aggregation needs an uplink outside the group.
  always_comb begin
    logic has;
    has = 1'b0;
    agg_ok = 1'b1;
    for (int m = 0; m < NUM_PORTS; m++) begin
      has = 1'b0;
      for (int q = 0; q < NUM_PORTS; q++) begin
        if (uplink_cmd[q] && (agg_grp[q] != agg_grp[cmd_p]) && (node_id[q] == node_id[m])) begin
          has = 1'b1;
        end
      end
      if ((agg_grp[cmd_p] != '0) && (agg_grp[m] == agg_grp[cmd_p]) && !has) begin
        agg_ok = 1'b0;
      end
    end
  end

  // Preconditions are checked in a fixed order; the first failure is reported.
  always_comb begin
    if (!glob_en) begin
      cmd_rej = REJ_NO_GLOBAL;
    end else if (!vlan_valid[cmd_p]) begin
      cmd_rej = REJ_NO_VLAN;
    end else if (!uplink_ok) begin
      cmd_rej = REJ_NO_UPLINK;
    end else if (!agg_ok) begin
      cmd_rej = REJ_AGG_NODE;
    end else if (alloc_cnt[MAP_AW] && !prot[cmd_p]) begin
      cmd_rej = REJ_MAP_FULL;
    end else begin
      cmd_rej = REJ_NONE;
    end
  end

  // Global control; dropping fabric_virtualization also drops the enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob_en <= 1'b0;
      fab_virt <= 1'b0;
    end else if (apb_wr && (paddr == ADDR_CTRL)) begin
      fab_virt <= pwdata[CTRL_FV_BIT];
      glob_en <= pwdata[CTRL_EN_BIT] & pwdata[CTRL_FV_BIT];
    end
  end

  // Protection flags; clearing the global enable unprotects every port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot <= '0;
    end else if (!glob_en) begin
      prot <= '0;
    end else if (cmd_wr && !cmd_en) begin
      prot[cmd_p] <= 1'b0;
    end else if (cmd_wr && (cmd_rej == REJ_NONE)) begin
      prot[cmd_p] <= 1'b1;
    end
  end

  // Mappings are handed out in request order and never reused.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alloc_cnt <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        map_idx[i] <= '0;
      end
    end else if (cmd_new) begin
      alloc_cnt <= alloc_cnt + 1'b1;
      map_idx[cmd_p] <= alloc_cnt[MAP_AW-1:0];
    end
  end

  // Port VLAN and aggregation attributes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlan_valid <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_vlan[i] <= '0;
        agg_grp[i] <= '0;
        node_id[i] <= '0;
      end
    end else if (apb_wr && (paddr == ADDR_VLAN)) begin
      vlan_valid[cmd_p] <= pwdata[VLAN_VALID_BIT];
      port_vlan[cmd_p] <= pwdata[VLAN_LSB +: VLAN_W];
    end else if (apb_wr && (paddr == ADDR_ATTR)) begin
      agg_grp[cmd_p] <= pwdata[AGG_LSB +: GRP_W];
      node_id[cmd_p] <= pwdata[NODE_LSB +: GRP_W];
    end
  end

  // Outcome of CTRL, CMD and VLAN-creation requests.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rej <= 1'b0;
      last_code <= REJ_NONE;
    end else if (apb_wr && (paddr == ADDR_CTRL)) begin
      last_rej <= pwdata[CTRL_EN_BIT] & ~pwdata[CTRL_FV_BIT];
      last_code <= (pwdata[CTRL_EN_BIT] & ~pwdata[CTRL_FV_BIT]) ? REJ_NO_FV : REJ_NONE;
    end else if (cmd_wr) begin
      last_rej <= cmd_en && (cmd_rej != REJ_NONE);
      last_code <= cmd_en ? cmd_rej : REJ_NONE;
    end else if (apb_wr && (paddr == ADDR_VCREATE)) begin
      last_rej <= glob_en && (pwdata[VLAN_W-1:0] >= INT_VLAN_LO);
      last_code <= (glob_en && (pwdata[VLAN_W-1:0] >= INT_VLAN_LO)) ? REJ_RESERVED : REJ_NONE;
    end
  end

  // Index for reading back the mapping table.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_rd_idx <= '0;
    end else if (apb_wr && (paddr == ADDR_MAPIDX)) begin
      map_rd_idx <= pwdata[MAP_AW-1:0];
    end
  end

  // The table records the user VLAN behind each internal VLAN.
  ppi_map_mem #(
    .AW(MAP_AW),
    .DW(VLAN_W)
  ) u_map (
    .pclk(pclk),
    .we(cmd_new),
    .waddr(alloc_cnt[MAP_AW-1:0]),
    .wdata(port_vlan[cmd_p]),
    .raddr(map_rd_idx),
    .rdata(map_rdata)
  );

  // Read data and error are captured in the wait state before pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= 1'b0;
        prdata <= '0;
        case (paddr)
          ADDR_CTRL: begin
            prdata[CTRL_EN_BIT] <= glob_en;
            prdata[CTRL_FV_BIT] <= fab_virt;
          end
          ADDR_PROT: prdata[NUM_PORTS-1:0] <= prot;
          ADDR_CMD, ADDR_VLAN, ADDR_ATTR, ADDR_VCREATE: prdata <= '0;
          ADDR_STATUS: begin
            prdata[ST_REJ_BIT] <= last_rej;
            prdata[ST_CODE_LSB +: 4] <= last_code;
            prdata[ST_CNT_LSB +: MAP_AW + 1] <= alloc_cnt;
          end
          ADDR_STP: prdata[NUM_PORTS-1:0] <= stp_block;
          ADDR_MAPIDX: prdata[MAP_AW-1:0] <= map_rd_idx;
          ADDR_MAPDATA: prdata[VLAN_W-1:0] <= map_rdata;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Spanning tree block flags follow protected membership.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stp_block <= '0;
    end else begin
      stp_block <= next_stp;
    end
  end

  // Ingress descriptors wait here; a stalled output fills it and drops in_ready.
  ppi_fifo #(
    .WIDTH(DESC_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_sw, in_flood, in_dest, in_tag, in_vlan, in_port}),
    .rd_valid(f_valid),
    .rd_ready(f_ready),
    .rd_data(f_data)
  );

  // The software flag travels along but cannot bypass the filter.
  assign {f_flood, f_dest, f_tag, f_vlan, f_src} = f_data[DESC_W-2:0];
  assign f_ready = !out_valid || out_ready;
  assign pop = f_valid && f_ready;

  // Egress mask: protected sources see uplinks only, whatever the VLAN.
  always_comb begin
    if (f_tag == TAG_OTHER) begin
      next_mask = '0;
    end else if (prot[f_src]) begin
      if (f_flood) begin
        next_mask = member_src & ~prot & ~src_bit;
      end else begin
        next_mask = f_dest & ~prot & ~src_bit;
      end
    end else if (f_flood) begin
      next_mask = member_src & ~src_bit;
    end else begin
      next_mask = f_dest & ~src_bit;
    end
  end

  // Output stage holds a result until the consumer takes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_mask <= '0;
      out_vlan <= '0;
      out_drop <= 1'b0;
    end else if (f_ready) begin
      out_valid <= f_valid;
      if (pop) begin
        out_mask <= next_mask;
        out_drop <= (f_tag == TAG_OTHER) || (next_mask == '0);
        out_vlan <= prot[f_src] ? INT_VLAN_LO + {3'h0, map_idx[f_src]} : f_vlan;
      end
    end
  end

  // Checks on the behaviour above.
  prot_glob_a: assert property (@(posedge pclk) disable iff (!presetn)
    (prot != '0) |-> $past(glob_en)) else $error("port protected without global enable");
  glob_fv_a: assert property (@(posedge pclk) disable iff (!presetn)
    glob_en |-> fab_virt) else $error("global enable set without fabric virtualization");
  prot_egress_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pop && prot[f_src]) |=> ((out_mask & $past(prot)) == '0))
    else $error("protected frame reached a protected port");
  tag_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pop && (f_tag == TAG_OTHER)) |=> (out_drop && (out_mask == '0)))
    else $error("unsupported tag not dropped");
  int_vlan_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pop && prot[f_src]) |=> ((out_vlan >= INT_VLAN_LO) && (out_vlan <= INT_VLAN_HI)))
    else $error("protected frame outside internal VLAN range");
  map_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alloc_cnt[MAP_AW] |=> $stable(alloc_cnt)) and (alloc_cnt <= (MAP_AW + 1)'(MAP_DEPTH)))
    else $error("mapping count exceeded");
  vlan_reserve_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && (paddr == ADDR_VCREATE) && glob_en && (pwdata[VLAN_W-1:0] >= INT_VLAN_LO))
    |=> (last_rej && (last_code == REJ_RESERVED))) else $error("reserved VLAN accepted");
  no_vlan_rej_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && cmd_en && glob_en && !vlan_valid[cmd_p])
    |=> (last_rej && (last_code == REJ_NO_VLAN))) else $error("port without VLAN accepted");
  uplink_rej_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && cmd_en && glob_en && vlan_valid[cmd_p] && !uplink_ok && !prot[cmd_p])
    |=> ($stable(alloc_cnt) && (last_code == REJ_NO_UPLINK)))
    else $error("protection accepted without uplink");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready ##1 !pready) else $error("bus answer timing wrong");
endmodule // ppi_filter

// *** testbench/ppi_port_model.sv ***
// Partner model of the switch ports that take filter results.
`timescale 1ns/1ps
module ppi_port_model
  import ppi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [NUM_PORTS-1:0] out_mask,
  input wire logic [VLAN_W-1:0] out_vlan,
  input wire logic out_drop
);
  logic [NUM_PORTS+VLAN_W:0] got_q[$];

  // Ready toggles when slow, so a result must stand across refused edges.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall && (!slow || !out_ready);
    end
  end

  // Each accepted result is queued whole for the bench to inspect in order.
  always @(posedge pclk) begin
    if (presetn && out_valid && out_ready) begin
      got_q.push_back({out_drop, out_vlan, out_mask});
    end
  end
endmodule // ppi_port_model

// *** testbench/ppi_filter_tb.sv ***
// Self-checking testbench of the protected port isolation filter.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, (a), (e)); end end
module ppi_filter_tb
  import ppi_pkg::*;
();
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, in_ready, out_valid, out_ready, out_drop;
  logic in_valid = 1'b0, in_flood = 1'b0, in_sw = 1'b0, slow = 1'b0, stall = 1'b0;
  logic [2:0] in_port = 3'h0;
  logic [1:0] in_tag = 2'h0;
  logic [VLAN_W-1:0] in_vlan = 13'h00A, out_vlan;
  logic [7:0] in_dest = 8'h00, out_mask, stp_block;
  logic [21:0] res;
  int err_total = 0, checks = 0, cyc = 0, acc;

  ppi_filter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_port(in_port),
    .in_vlan(in_vlan), .in_tag(in_tag), .in_dest(in_dest), .in_flood(in_flood),
    .in_sw(in_sw), .out_valid(out_valid), .out_ready(out_ready), .out_mask(out_mask),
    .out_vlan(out_vlan), .out_drop(out_drop), .stp_block(stp_block));

  ppi_port_model pm_u (.pclk(pclk), .presetn(presetn), .slow(slow), .stall(stall),
    .out_valid(out_valid), .out_ready(out_ready), .out_mask(out_mask),
    .out_vlan(out_vlan), .out_drop(out_drop));

  // Free-running 40 MHz clock.
  always #12.5 pclk = ~pclk;

  // A hang is cut short long before the run could drift past its budget.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Expected status word from a code and a mapping count.
  function automatic logic [31:0] st(input logic [3:0] c, input logic [10:0] n);
    return {5'h00, n, 8'h00, c, 3'h0, c != 4'h0};
  endfunction

  // One descriptor of VLAN 10, held until the FIFO takes it.
  task automatic send(input logic [2:0] p, input logic [1:0] t, input logic [7:0] d,
                      input logic f, input logic s);
    in_valid <= 1'b1;
    in_port <= p;
    in_tag <= t;
    in_dest <= d;
    in_flood <= f;
    in_sw <= s;
    do begin
      @(posedge pclk);
    end while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // Next result seen by the port model.
  task automatic getr();
    while (pm_u.got_q.size() == 0) begin
      @(posedge pclk);
    end
    res = pm_u.got_q.pop_front();
  endtask

  // Main sequence: configuration checks first, then traffic, then the buffer.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_PROT); `CHK(rdat, 32'h0)
    rd(ADDR_STP); `CHK(rdat, 32'h0)
    wr(ADDR_CMD, 32'h101); rd(ADDR_STATUS); `CHK(rdat, st(4'h1, 11'h0))
    wr(ADDR_CTRL, 32'h1); rd(ADDR_STATUS); `CHK(rdat, st(4'h6, 11'h0))
    rd(ADDR_CTRL); `CHK(rdat, 32'h0)
    wr(ADDR_CTRL, 32'h3); rd(ADDR_CTRL); `CHK(rdat, 32'h3)
    wr(ADDR_VCREATE, 32'h1C00); rd(ADDR_STATUS); `CHK(rdat, st(4'h7, 11'h0))
    wr(ADDR_VCREATE, 32'h1BFF); rd(ADDR_STATUS); `CHK(rdat, st(4'h0, 11'h0))
    wr(ADDR_CMD, 32'h101); rd(ADDR_STATUS); `CHK(rdat, st(4'h2, 11'h0))
    for (int p = 0; p < 6; p++) begin
      wr(ADDR_VLAN, {1'b1, 2'h0, 13'h00A, 13'h0000, 3'(p)});
    end
    wr(ADDR_VLAN, {1'b1, 2'h0, 13'h014, 16'h0006});
    wr(ADDR_CMD, 32'h106); rd(ADDR_STATUS); `CHK(rdat, st(4'h3, 11'h0))
    wr(ADDR_ATTR, 32'h114);
    wr(ADDR_ATTR, 32'h215);
    wr(ADDR_CMD, 32'h104); rd(ADDR_STATUS); `CHK(rdat, st(4'h4, 11'h0))
    for (int p = 1; p < 4; p++) begin
      wr(ADDR_CMD, 32'h100 + p);
      rd(ADDR_STATUS); `CHK(rdat, st(4'h0, 11'(p)))
    end
    rd(ADDR_PROT); `CHK(rdat, 32'h0E)
    wr(ADDR_PROT, 32'hFF); rd(ADDR_PROT); `CHK(rdat, 32'h0E)
    rd(ADDR_STP); `CHK(rdat, 32'h3F)
    `CHK(stp_block, 8'h3F)
    wr(ADDR_MAPIDX, 32'h1); rd(ADDR_MAPDATA); `CHK(rdat, 32'h00A)
    rd(ADDR_MAPIDX); `CHK(rdat, 32'h1)
    rd(8'h40); `CHK({rerr, rdat}, 33'h100000000)
    // Traffic with a slow far side, so each result must hold under stalls.
    slow <= 1'b1;
    send(3'h1, TAG_VLAN, 8'hFF, 1'b0, 1'b0); getr(); `CHK(res, {1'b0, 13'h1C00, 8'hF1})
    send(3'h1, TAG_VLAN, 8'hFF, 1'b0, 1'b1); getr(); `CHK(res, {1'b0, 13'h1C00, 8'hF1})
    send(3'h1, TAG_VLAN, 8'h04, 1'b0, 1'b0); getr(); `CHK({res[21], res[7:0]}, 9'h100)
    for (int t = 0; t < 3; t++) begin
      send(3'h0, 2'(t), 8'hFF, 1'b0, 1'b0); getr(); `CHK(res, {1'b0, 13'h00A, 8'hFE})
    end
    send(3'h0, TAG_OTHER, 8'hFF, 1'b0, 1'b0); getr(); `CHK(res[21], 1'b1)
    send(3'h2, TAG_NONE, 8'h00, 1'b1, 1'b0); getr(); `CHK(res, {1'b0, 13'h1C01, 8'h31})
    send(3'h3, TAG_PRIO, 8'h00, 1'b1, 1'b0); getr(); `CHK(res, {1'b0, 13'h1C02, 8'h31})
    send(3'h0, TAG_NONE, 8'h00, 1'b1, 1'b0); getr(); `CHK(res, {1'b0, 13'h00A, 8'h3E})
    // Fill the buffer with the far side stalled, then drain it.
    stall <= 1'b1;
    repeat (2) @(posedge pclk);
    pm_u.got_q.delete();
    in_valid <= 1'b1;
    in_port <= 3'h0;
    in_tag <= TAG_NONE;
    in_flood <= 1'b0;
    acc = 0;
    do begin
      @(posedge pclk);
      if (in_ready === 1'b1) acc++;
    end while (in_ready === 1'b1 && acc < 40);
    in_valid <= 1'b0;
    `CHK(acc, FIFO_DEPTH + 1)
    stall <= 1'b0;
    while (pm_u.got_q.size() < acc) @(posedge pclk);
    repeat (4) @(posedge pclk);
    `CHK(pm_u.got_q.size(), acc)
    `CHK({in_ready, out_valid}, 2'b10)
    // Removing protection, then the global enable, releases every port.
    wr(ADDR_CMD, 32'h3); rd(ADDR_PROT); `CHK(rdat, 32'h06)
    wr(ADDR_CTRL, 32'h2); rd(ADDR_PROT); `CHK(rdat, 32'h0)
    end_of_test();
  end
endmodule // ppi_filter_tb
